// ===== design/tsa_pkg.sv
// Purpose: Shared types and constants for the tag state and anticollision block
// Assumes: Commands arrive already decoded, one per valid cycle
// Notes: Command encodings are internal to this block

package tsa_pkg;

   localparam int ID_W = 8;
   localparam int NIB_W = 4;
   localparam int SLOT_CNT = 16;
   localparam int LFSR_W = 16;
   localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hACE1;
   localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hB400;
   // Bit positions of the random word used for each fresh value
   localparam int RND_ID_LSB = 0;
   localparam int RND_NIB_LSB = 8;
   localparam logic [NIB_W-1:0] SLOT_ZERO = 4'h0;
   localparam logic [NIB_W-1:0] SLOT_LAST = 4'hF;
   localparam logic [ID_W-1:0] ID_RST = 8'h00;

   typedef enum logic [2:0] {
      TAG_POWER_OFF = 3'b000,
      TAG_READY = 3'b001,
      TAG_INVENTORY = 3'b011,
      TAG_SELECTED = 3'b010,
      TAG_DESELECTED = 3'b110,
      TAG_DEACTIVATED = 3'b111
   } tsa_state_e;

   typedef enum logic [3:0] {
      CMD_UNKNOWN = 4'h0,
      CMD_INVENTORY_BEGIN = 4'h1,
      CMD_SLOT_ZERO_CALL = 4'h2,
      CMD_SLOT_TICK = 4'h3,
      CMD_CHOOSE_TAG = 4'h4,
      CMD_RETIRE_TAG = 4'h5,
      CMD_BLOCK_FETCH = 4'h6,
      CMD_BLOCK_STORE = 4'h7,
      CMD_UNIQUE_SERIAL_FETCH = 4'h8
   } tsa_cmd_e;

   typedef struct packed {
      logic valid;
      logic frame_ok;
      tsa_cmd_e kind;
      logic [ID_W-1:0] tag_id;
      logic [NIB_W-1:0] slot_index_param;
   } tsa_cmd_s;

   typedef struct packed {
      logic valid;
      logic [ID_W-1:0] tag_short_id;
   } tsa_reply_s;

   typedef struct packed {
      logic valid;
      tsa_cmd_e kind;
   } tsa_mem_req_s;

endpackage : tsa_pkg

// ===== design/tsa_lfsr.sv
// Purpose: Free-running Galois LFSR used as the random source
// Assumes: Clock runs continuously while the tag is powered
// Notes: Seed must be non-zero

`timescale 1ns/1ps

module tsa_lfsr #(
   parameter int W = 16,
   parameter logic [W-1:0] SEED = 16'hACE1,
   parameter logic [W-1:0] TAPS = 16'hB400
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   output logic [W-1:0] rnd_o
);

   logic [W-1:0] lfsr_r;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lfsr_r <= SEED;
      end else begin
         lfsr_r <= {1'b0, lfsr_r[W-1:1]} ^ (lfsr_r[0] ? TAPS : '0);
      end
   end

   assign rnd_o = lfsr_r;

endmodule : tsa_lfsr

// ===== design/tsa_cmd_gate.sv
// Purpose: Filters decoded frames down to commands the state logic may act on
// Assumes: frame_ok reports the checksum result of the same frame
// Notes: Purely combinational

`timescale 1ns/1ps

module tsa_cmd_gate (
   input wire logic field_ok_i,
   input tsa_pkg::tsa_cmd_s cmd_i,
   output logic accept_o
);
   import tsa_pkg::*;

   // Bad checksum or unknown opcode is treated as no frame at all
   assign accept_o = field_ok_i & cmd_i.valid & cmd_i.frame_ok &
                     (cmd_i.kind != CMD_UNKNOWN);

endmodule : tsa_cmd_gate

// ===== design/contactless_tag_state_anticollision.sv
// Purpose: State tracking and slotted anticollision of a contactless memory tag
// Assumes: Decoded commands arrive as one-cycle valid strobes; field_ok_i is synchronous
// Notes: Replies and memory requests are one-cycle pulses one clock after the command

`timescale 1ns/1ps

module contactless_tag_state_anticollision #(
   parameter int LFSR_WIDTH = tsa_pkg::LFSR_W
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic field_ok_i,
   input tsa_pkg::tsa_cmd_s cmd_i,
   output tsa_pkg::tsa_state_e state_o,
   output logic [tsa_pkg::ID_W-1:0] tag_short_id_o,
   output tsa_pkg::tsa_reply_s reply_o,
   output tsa_pkg::tsa_mem_req_s mem_req_o
);
   import tsa_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   tsa_state_e state_r;
   tsa_state_e state_nxt;
   logic [ID_W-1:0] tag_id_r;
   logic [ID_W-1:0] tag_id_nxt;
   logic replied_r;
   logic replied_nxt;
   tsa_reply_s reply_r;
   tsa_reply_s reply_nxt;
   tsa_mem_req_s mem_req_r;
   logic [LFSR_WIDTH-1:0] rnd;
   logic accept;
   logic id_match;
   logic [NIB_W-1:0] slot_select_nibble;
   logic [NIB_W-1:0] new_nibble;
   logic tick_slot_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Random source and command filter

   tsa_lfsr #(
      .W(LFSR_WIDTH),
      .SEED(LFSR_WIDTH'(LFSR_SEED)),
      .TAPS(LFSR_WIDTH'(LFSR_TAPS))
   ) u_lfsr (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .rnd_o(rnd)
   );

   tsa_cmd_gate u_gate (
      .field_ok_i(field_ok_i),
      .cmd_i(cmd_i),
      .accept_o(accept)
   );

   assign id_match = (cmd_i.tag_id == tag_id_r);
   assign slot_select_nibble = tag_id_r[NIB_W-1:0];
   assign new_nibble = rnd[RND_NIB_LSB +: NIB_W];
   // Slot 0 belongs to the zero call only
   assign tick_slot_ok = (cmd_i.slot_index_param != SLOT_ZERO);

   ////////////////////////////////////////////////////////////////////////////
   // Next state, identifier and reply

   always_comb begin
      state_nxt = state_r;
      tag_id_nxt = tag_id_r;
      replied_nxt = replied_r;
      reply_nxt = '0;
      if (!field_ok_i) begin
         state_nxt = TAG_POWER_OFF;
         replied_nxt = 1'b0;
      end else if (state_r == TAG_POWER_OFF) begin
         state_nxt = TAG_READY;
         tag_id_nxt = rnd[RND_ID_LSB +: ID_W];
         replied_nxt = 1'b0;
      end else if (accept) begin
         case (state_r)
            TAG_READY: begin
               if (cmd_i.kind == CMD_INVENTORY_BEGIN) begin
                  state_nxt = TAG_INVENTORY;
                  tag_id_nxt = rnd[RND_ID_LSB +: ID_W];
                  reply_nxt.valid = 1'b1;
                  reply_nxt.tag_short_id = rnd[RND_ID_LSB +: ID_W];
                  replied_nxt = 1'b1;
               end
            end
            TAG_INVENTORY: begin
               case (cmd_i.kind)
                  CMD_INVENTORY_BEGIN: begin
                     tag_id_nxt = rnd[RND_ID_LSB +: ID_W];
                     reply_nxt.valid = 1'b1;
                     reply_nxt.tag_short_id = rnd[RND_ID_LSB +: ID_W];
                     replied_nxt = 1'b1;
                  end
                  CMD_SLOT_ZERO_CALL: begin
                     // New round: earlier replies no longer count
                     tag_id_nxt = {tag_id_r[ID_W-1:NIB_W], new_nibble};
                     replied_nxt = 1'b0;
                     if (new_nibble == SLOT_ZERO) begin
                        reply_nxt.valid = 1'b1;
                        reply_nxt.tag_short_id = {tag_id_r[ID_W-1:NIB_W], new_nibble};
                        replied_nxt = 1'b1;
                     end
                  end
                  CMD_SLOT_TICK: begin
                     if (tick_slot_ok && !replied_r &&
                         (slot_select_nibble == cmd_i.slot_index_param)) begin
                        reply_nxt.valid = 1'b1;
                        reply_nxt.tag_short_id = tag_id_r;
                        replied_nxt = 1'b1;
                     end
                  end
                  CMD_CHOOSE_TAG: begin
                     if (id_match) begin
                        state_nxt = TAG_SELECTED;
                     end
                  end
                  default: begin
                  end
               endcase
            end
            TAG_SELECTED: begin
               case (cmd_i.kind)
                  CMD_CHOOSE_TAG: begin
                     if (!id_match) begin
                        state_nxt = TAG_DESELECTED;
                     end
                  end
                  CMD_RETIRE_TAG: begin
                     state_nxt = TAG_DEACTIVATED;
                  end
                  default: begin
                  end
               endcase
            end
            TAG_DESELECTED: begin
               if ((cmd_i.kind == CMD_CHOOSE_TAG) && id_match) begin
                  state_nxt = TAG_SELECTED;
               end
            end
            TAG_DEACTIVATED: begin
            end
            default: begin
               state_nxt = TAG_POWER_OFF;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= TAG_POWER_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tag_id_r <= ID_RST;
         replied_r <= 1'b0;
      end else begin
         tag_id_r <= tag_id_nxt;
         replied_r <= replied_nxt;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reply_r <= '0;
      end else begin
         reply_r <= reply_nxt;
      end
   end

   // Memory commands are passed on only while selected
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mem_req_r <= '0;
      end else begin
         mem_req_r.valid <= accept && (state_r == TAG_SELECTED) &&
                            ((cmd_i.kind == CMD_BLOCK_FETCH) ||
                             (cmd_i.kind == CMD_BLOCK_STORE) ||
                             (cmd_i.kind == CMD_UNIQUE_SERIAL_FETCH));
         mem_req_r.kind <= cmd_i.kind;
      end
   end

   assign state_o = state_r;
   assign tag_short_id_o = tag_id_r;
   assign reply_o = reply_r;
   assign mem_req_o = mem_req_r;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   a_power_off_silent: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      !field_ok_i |=> (state_r == TAG_POWER_OFF) && !reply_r.valid && !mem_req_r.valid)
      else $error("tag not silent in power-off");

   a_power_up_ready: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (state_r == TAG_POWER_OFF) && field_ok_i |=> (state_r == TAG_READY) && !reply_r.valid)
      else $error("power-up did not enter ready");

   a_ready_ignores: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (state_r == TAG_READY) && field_ok_i && (cmd_i.kind != CMD_INVENTORY_BEGIN)
      |=> (state_r == TAG_READY) && !reply_r.valid && $stable(tag_id_r))
      else $error("ready state acted on a command");

   a_begin_reply_now: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      accept && (cmd_i.kind == CMD_INVENTORY_BEGIN) &&
      ((state_r == TAG_READY) || (state_r == TAG_INVENTORY))
      |=> reply_r.valid && (reply_r.tag_short_id == tag_id_r) && (state_r == TAG_INVENTORY))
      else $error("inventory begin reply wrong");

   a_zero_call_rule: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      accept && (state_r == TAG_INVENTORY) && (cmd_i.kind == CMD_SLOT_ZERO_CALL)
      |=> (reply_r.valid == (tag_id_r[NIB_W-1:0] == SLOT_ZERO)) &&
          (tag_id_r[ID_W-1:NIB_W] == $past(tag_id_r[ID_W-1:NIB_W])))
      else $error("slot zero call reply mismatch");

   a_tick_match: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      accept && (state_r == TAG_INVENTORY) && (cmd_i.kind == CMD_SLOT_TICK) &&
      (cmd_i.slot_index_param != slot_select_nibble) |=> !reply_r.valid)
      else $error("slot tick replied out of slot");

   a_tick_reply_id: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      accept && (state_r == TAG_INVENTORY) && (cmd_i.kind == CMD_SLOT_TICK) && !replied_r &&
      tick_slot_ok && (cmd_i.slot_index_param == slot_select_nibble)
      |=> reply_r.valid && (reply_r.tag_short_id == $past(tag_id_r)))
      else $error("slot tick missed its slot");

   a_tick_zero_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      accept && (state_r == TAG_INVENTORY) && (cmd_i.kind == CMD_SLOT_TICK) &&
      (cmd_i.slot_index_param == SLOT_ZERO) |=> !reply_r.valid)
      else $error("slot tick answered slot zero");

   // A reply already seen this round blocks the tick taken in the same cycle
   a_one_reply_round: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      reply_r.valid && (state_r == TAG_INVENTORY) && accept && (cmd_i.kind == CMD_SLOT_TICK)
      |=> !reply_r.valid)
      else $error("second reply in one round");

   a_choose_match: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      accept && (cmd_i.kind == CMD_CHOOSE_TAG) && id_match &&
      ((state_r == TAG_INVENTORY) || (state_r == TAG_DESELECTED)) |=> (state_r == TAG_SELECTED))
      else $error("matching choose did not select");

   a_selected_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (state_r == TAG_SELECTED) |=> !reply_r.valid)
      else $error("selected tag answered anticollision");

   a_mem_sel_only: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (state_r != TAG_SELECTED) |=> !mem_req_r.valid)
      else $error("memory request outside selected state");

   a_deselect_other: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      accept && (state_r == TAG_SELECTED) && (cmd_i.kind == CMD_CHOOSE_TAG) && !id_match
      |=> (state_r == TAG_DESELECTED))
      else $error("mismatching choose did not deselect");

   a_retire_tag: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      accept && (state_r == TAG_SELECTED) && (cmd_i.kind == CMD_RETIRE_TAG)
      |=> (state_r == TAG_DEACTIVATED) ##1
          ($past(field_ok_i) ? (state_r == TAG_DEACTIVATED) : 1'b1))
      else $error("retire did not deactivate");

   a_deact_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (state_r == TAG_DEACTIVATED) && field_ok_i
      |=> (state_r == TAG_DEACTIVATED) && !reply_r.valid && !mem_req_r.valid)
      else $error("deactivated tag left its state");

   a_invalid_frame: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      cmd_i.valid && !cmd_i.frame_ok && field_ok_i && (state_r != TAG_POWER_OFF)
      |=> $stable(state_r) && $stable(tag_id_r) && !reply_r.valid)
      else $error("invalid frame changed the tag");

endmodule : contactless_tag_state_anticollision

// ===== testbench/tsa_reader_model.sv
// Purpose: Reader side of the air interface, issuing decoded command frames
// Assumes: One frame per call, driven just after the rising edge
// Notes: Expected outcome of each frame is queued for the bench monitor

`timescale 1ns/1ps

module tsa_reader_model (
   input wire logic ref_clk_i,
   output tsa_pkg::tsa_cmd_s cmd_o
);
   import tsa_pkg::*;

   // {kind[18:15], old id[14:7], reply mode[6:5], state[4:2], mem[1], keep id[0]}
   logic [18:0] note_q[$];

   initial cmd_o = '0;

   ////////////////////////////////////////////////////////////////////////////////
   // Idle fields are scrambled so a stale frame never looks valid by accident
   task automatic issue(input tsa_cmd_e kind, input logic [7:0] id, input logic [3:0] sn,
                        input logic ok, input logic [18:0] note, input int gap);
      repeat (gap) @(posedge ref_clk_i);
      #1;
      cmd_o <= '{valid: 1'b1, frame_ok: ok, kind: kind, tag_id: id, slot_index_param: sn};
      note_q.push_back(note);
      @(posedge ref_clk_i);
      #1;
      cmd_o <= {1'b0, ~cmd_o[16:0]};
   endtask : issue

endmodule : tsa_reader_model

// ===== testbench/tb.sv
// Purpose: Self-checking bench for the tag state and anticollision block
// Assumes: Reader model drives frames; monitor checks one note per frame
// Notes: Tag identifiers are random, so expectations follow the seen identifier

`timescale 1ns/1ps

`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module tb;
   import tsa_pkg::*;

   logic ref_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic field_ok_i = 1'b0;
   logic pend = 1'b0;
   tsa_cmd_s cmd;
   tsa_state_e state;
   logic [7:0] tag_id;
   tsa_reply_s reply;
   tsa_mem_req_s mem_req;
   int err_count = 0;
   int check_count = 0;

   always #50 ref_clk_i = ~ref_clk_i;

   tsa_reader_model u_tsa_reader_model (.ref_clk_i(ref_clk_i), .cmd_o(cmd));

   contactless_tag_state_anticollision u_contactless_tag_state_anticollision (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .field_ok_i(field_ok_i), .cmd_i(cmd),
      .state_o(state), .tag_short_id_o(tag_id), .reply_o(reply), .mem_req_o(mem_req));

   ////////////////////////////////////////////////////////////////////////////////
   // Monitor: one note per frame, checked once the answer cycle has settled
   always @(posedge ref_clk_i) pend <= cmd.valid;

   always @(negedge ref_clk_i) begin
      logic [18:0] n;
      logic exp_rv;
      if (pend) begin
         n = u_tsa_reader_model.note_q.pop_front();
         exp_rv = (n[6:5] == 2'd2) ? (tag_id[3:0] === 4'h0) : n[5];
         `CHK("reply valid", exp_rv, reply.valid)
         if (reply.valid === 1'b1) `CHK("reply id", tag_id, reply.tag_short_id)
         `CHK("state", n[4:2], state)
         `CHK("mem valid", n[1], mem_req.valid)
         if (mem_req.valid === 1'b1) `CHK("mem kind", n[18:15], mem_req.kind)
         if (n[0]) `CHK("id kept", n[14:7], tag_id)
         if (n[6:5] == 2'd2) `CHK("id high", n[14:11], tag_id[7:4])
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] rnd8();
      return 8'($urandom_range(255));
   endfunction : rnd8

   task automatic send(input tsa_cmd_e k, input logic [7:0] id, input logic [3:0] sn,
                       input logic ok, input logic [1:0] mode, input tsa_state_e exp_state,
                       input logic mv, input logic keep);
      u_tsa_reader_model.issue(k, id, sn, ok, {k, tag_id, mode, exp_state, mv, keep},
                               $urandom_range(2));
   endtask : send

   task automatic ign(input tsa_cmd_e k, input logic [7:0] id, input logic ok);
      send(k, id, 4'($urandom_range(15)), ok, 2'd0, state, 1'b0, 1'b1);
   endtask : ign

   task automatic round();
      logic [3:0] nib;
      logic done;
      send(CMD_SLOT_ZERO_CALL, rnd8(), 4'h0, 1'b1, 2'd2, TAG_INVENTORY, 1'b0, 1'b0);
      nib = tag_id[3:0];
      done = (nib == 4'h0);
      for (int n = 1; n < 16; n++) begin
         send(CMD_SLOT_TICK, rnd8(), n[3:0], 1'b1, {1'b0, n[3:0] == nib && !done},
              TAG_INVENTORY, 1'b0, 1'b1);
         // Back-to-back tick lands while the reply pulse still stands
         if (n[3:0] == nib) u_tsa_reader_model.issue(CMD_SLOT_TICK, rnd8(),
            4'($urandom_range(15)), 1'b1,
            {CMD_SLOT_TICK, tag_id, 2'd0, TAG_INVENTORY, 2'b01}, 0);
      end
      send(CMD_SLOT_TICK, rnd8(), 4'h0, 1'b1, 2'd0, TAG_INVENTORY, 1'b0, 1'b1);
   endtask : round

   task automatic power_up();
      @(posedge ref_clk_i);
      #1 field_ok_i = 1'b1;
      repeat (2) @(posedge ref_clk_i);
      #1;
      `CHK("ready", TAG_READY, state)
   endtask : power_up

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : complete_run

   initial begin
      repeat (5000) @(posedge ref_clk_i);
      err_count++;
      complete_run();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(87));
      repeat (10) @(posedge ref_clk_i);
      #1 rst_b_i = 1'b1;
      ign(CMD_INVENTORY_BEGIN, rnd8(), 1'b1);
      power_up();
      for (int k = 2; k <= 8; k++) ign(tsa_cmd_e'(k), tag_id, 1'b1);
      ign(CMD_INVENTORY_BEGIN, rnd8(), 1'b0);
      ign(CMD_UNKNOWN, rnd8(), 1'b1);
      $display("test ready done");
      repeat (2) send(CMD_INVENTORY_BEGIN, rnd8(), 4'h0, 1'b1, 2'd1, TAG_INVENTORY,
                      1'b0, 1'b0);
      repeat (3) round();
      $display("test anticollision done");
      send(CMD_CHOOSE_TAG, tag_id ^ 8'($urandom_range(255, 1)), 4'h0, 1'b1, 2'd0,
           TAG_INVENTORY, 1'b0, 1'b1);
      send(CMD_CHOOSE_TAG, tag_id, 4'h0, 1'b1, 2'd0, TAG_SELECTED, 1'b0, 1'b1);
      for (int k = 6; k <= 8; k++) send(tsa_cmd_e'(k), rnd8(), 4'h0, 1'b1, 2'd0, TAG_SELECTED,
                                        1'b1, 1'b1);
      for (int k = 1; k <= 4; k++) ign(tsa_cmd_e'(k), tag_id, 1'b1);
      send(CMD_CHOOSE_TAG, tag_id ^ 8'h01, 4'h0, 1'b1, 2'd0, TAG_DESELECTED,
           1'b0, 1'b1);
      for (int k = 1; k <= 8; k++) ign(tsa_cmd_e'(k), tag_id ^ 8'h80, 1'b1);
      send(CMD_CHOOSE_TAG, tag_id, 4'h0, 1'b1, 2'd0, TAG_SELECTED, 1'b0, 1'b1);
      send(CMD_RETIRE_TAG, rnd8(), 4'h0, 1'b1, 2'd0, TAG_DEACTIVATED, 1'b0, 1'b1);
      for (int k = 1; k <= 8; k++) ign(tsa_cmd_e'(k), tag_id, 1'b1);
      $display("test select done");
      @(posedge ref_clk_i);
      #1 field_ok_i = 1'b0;
      @(posedge ref_clk_i);
      #1;
      `CHK("power off", TAG_POWER_OFF, state)
      ign(CMD_INVENTORY_BEGIN, rnd8(), 1'b1);
      power_up();
      send(CMD_INVENTORY_BEGIN, rnd8(), 4'h0, 1'b1, 2'd1, TAG_INVENTORY, 1'b0, 1'b0);
      $display("test power cycle done");
      repeat (3) @(posedge ref_clk_i);
      complete_run();
   end

endmodule : tb
